// ===== tgts_pkg.sv
// Purpose: Shared constants of the general purpose timer set
// Assumes: 16-bit register words, word addressed register port
// Notes:   Offsets and field positions used by the timer set and the bench
package tgts_pkg;

  // ****************************************
  // Register port geometry
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_FIRST_CTRL  = 4'h0;
  localparam logic [3:0] OFS_FIRST_COUNT = 4'h1;
  localparam logic [3:0] OFS_FIRST_PER   = 4'h2;
  localparam logic [3:0] OFS_SECOND_CTRL = 4'h3;
  localparam logic [3:0] OFS_PAIR_CNT_LO = 4'h4;
  localparam logic [3:0] OFS_PAIR_PER_LO = 4'h5;
  localparam logic [3:0] OFS_THIRD_CTRL  = 4'h6;
  localparam logic [3:0] OFS_PAIR_CNT_HI = 4'h7;
  localparam logic [3:0] OFS_PAIR_PER_HI = 4'h8;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int unsigned RUN_BIT  = 15;
  localparam int unsigned IDLE_BIT = 13;
  localparam int unsigned GATE_BIT = 6;
  localparam int unsigned PS_MSB   = 5;
  localparam int unsigned PS_LSB   = 4;
  localparam int unsigned WIDE_BIT = 3;
  localparam int unsigned SYNC_BIT = 2;
  localparam int unsigned SRC_BIT  = 1;

  // ****************************************
  // Implemented bits and reset values
  // ****************************************
  localparam logic [15:0] FIRST_CTRL_MASK  = 16'hA076;
  localparam logic [15:0] SECOND_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] THIRD_CTRL_MASK  = 16'hA072;
  localparam logic [15:0] CTRL_RST         = 16'h0000;
  localparam logic [15:0] COUNT_RST        = 16'h0000;
  localparam logic [15:0] PERIOD_RST       = 16'hFFFF;

  // ****************************************
  // Prescale terminal phases
  // ****************************************
  localparam logic [7:0] PS_LIM_1   = 8'h00;
  localparam logic [7:0] PS_LIM_8   = 8'h07;
  localparam logic [7:0] PS_LIM_64  = 8'h3F;
  localparam logic [7:0] PS_LIM_256 = 8'hFF;

  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: ps_limit = PS_LIM_1;
      2'b01: ps_limit = PS_LIM_8;
      2'b10: ps_limit = PS_LIM_64;
      default: ps_limit = PS_LIM_256;
    endcase
  endfunction

endpackage

// ===== tgts_prescaler.sv
// Purpose: Input clock prescaler of one timer
// Assumes: each clk_sys cycle with tick_in high is one input tick
// Notes:   Phase restarts while clear is high
`timescale 1ns/10ps
module tgts_prescaler #(
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] select,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [CNT_W-1:0] phase;
  logic [CNT_W-1:0] limit;

  // ****************************************
  // Divide by 1, 8, 64 or 256
  // ****************************************
  assign limit    = CNT_W'(tgts_pkg::ps_limit(select));
  assign tick_out = tick_in && (phase == limit);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= '0;
    end else if (clear) begin
      phase <= '0;
    end else if (tick_in) begin
      phase <= tick_out ? '0 : CNT_W'(phase + 1'b1);
    end
  end

endmodule

// ===== tgts_pin_sync.sv
// Purpose: Two-stage synchroniser and edge finder for one pin
// Assumes: Pin is asynchronous to clk_sys
// Notes:   Edges are seen from the second stage onward
`timescale 1ns/10ps
module tgts_pin_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Pin
  input  wire logic pin,
  // Synchronised view
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic prev;

  // ****************************************
  // Synchroniser and edge history
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level && !prev;
  assign fall = !level && prev;

endmodule

// ===== tgts_timer_set.sv
// Purpose: First timer plus cascadable second/third timer pair
// Assumes: clk_sys is the instruction clock, 100 MHz
// Notes:   Word-addressed register port, read data one cycle later
//
// Contract
// - First timer run bit 15 starts counting when one, stops when zero.
// - Idle-stop bit one halts the timer in Idle; zero keeps it counting.
// - Gate accumulation works only with internal clock; ignored with external.
// - Prescale codes 00,01,10,11 divide by 1, 8, 64, 256.
// - First timer external clock sync bit chooses synchronised path; ignored internally.
// - Clock-source bit one counts external pin rising edges, zero instruction clock.
// - Unimplemented first control bits 14, 12-7, 3, 0 read zero.
// - Implemented first control bits are read/write and reset to zero.
// - Second and third timers cascade to 32 bits only when pair-wide set.
// - In 32-bit mode second holds low word, third high word.
// - In 32-bit mode third control bits are ignored; second controls all.
// - 32-bit mode uses second clock and gate; interrupt via third flag.
// - 32-bit period is third period high word, second period low word.
// - 32-bit count matching 32-bit period raises an interrupt request.
// - Pair-wide clear: two independent 16-bit timers, no asynchronous counting.
// - Only the combined pair drives the ADC trigger, never the first timer.
// - Second and third timers each offer a time base to capture/compare.
// - Paired timers keep operating in Idle while their idle-stop bit is clear.
// - Combined count is readable as third (high) and second (low) counts.
// - First timer interrupts on period match or gate falling edge.
// - Pair-wide select is bit 3 of second control register.
// - 32-bit timer runs in Idle only if second idle-stop is clear.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module tgts_timer_set (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [15:0] reg_rdata,
  // Device power state
  input  wire logic        idle_mode,
  // External clock and gate pins
  input  wire logic        first_timer_ext_clock_pin,
  input  wire logic        second_ext_clock_pin,
  input  wire logic        third_ext_clock_pin,
  // Event requests
  output logic             first_irq,
  output logic             second_irq,
  output logic             third_irq,
  output logic             adc_trigger,
  // Time bases for capture and compare
  output logic      [15:0] second_time_base,
  output logic      [15:0] third_time_base
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] first_timer_control;
  logic [15:0] second_timer_control;
  logic [15:0] third_timer_control;
  logic [15:0] first_count;
  logic [15:0] first_period;
  logic [15:0] pair_count_low;
  logic [15:0] pair_count_high;
  logic [15:0] pair_period_low;
  logic [15:0] pair_period_high;

  logic [2:0]  pin_level;
  logic [2:0]  pin_rise;
  logic [2:0]  pin_fall;
  logic [2:0]  ps_clear;
  logic [2:0]  ps_in;
  logic [2:0]  ps_tick;
  logic        sync_edge1;
  logic        edge1;
  logic        pair_wide_mode;
  logic [15:0] cfg2;
  logic [15:0] cfg3;
  logic [2:0]  run;
  logic [2:0]  gated;
  logic [2:0]  gate_fall_ev;
  logic        wide_match;
  logic        wr_first_cnt;
  logic        wr_lo_cnt;
  logic        wr_hi_cnt;
  logic [31:0] next_pair;
  logic [15:0] next_rdata;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      first_timer_control  <= tgts_pkg::CTRL_RST;
      second_timer_control <= tgts_pkg::CTRL_RST;
      third_timer_control  <= tgts_pkg::CTRL_RST;
      first_period         <= tgts_pkg::PERIOD_RST;
      pair_period_low      <= tgts_pkg::PERIOD_RST;
      pair_period_high     <= tgts_pkg::PERIOD_RST;
    end else if (reg_we) begin
      unique case (reg_addr)
        tgts_pkg::OFS_FIRST_CTRL:
          first_timer_control <= reg_wdata & tgts_pkg::FIRST_CTRL_MASK;
        tgts_pkg::OFS_SECOND_CTRL:
          second_timer_control <= reg_wdata & tgts_pkg::SECOND_CTRL_MASK;
        tgts_pkg::OFS_THIRD_CTRL:
          third_timer_control <= reg_wdata & tgts_pkg::THIRD_CTRL_MASK;
        tgts_pkg::OFS_FIRST_PER: first_period <= reg_wdata;
        tgts_pkg::OFS_PAIR_PER_LO: pair_period_low <= reg_wdata;
        tgts_pkg::OFS_PAIR_PER_HI: pair_period_high <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign wr_first_cnt = reg_we && (reg_addr == tgts_pkg::OFS_FIRST_COUNT);
  assign wr_lo_cnt    = reg_we && (reg_addr == tgts_pkg::OFS_PAIR_CNT_LO);
  assign wr_hi_cnt    = reg_we && (reg_addr == tgts_pkg::OFS_PAIR_CNT_HI);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  tgts_pin_sync u_sync1 (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin     (first_timer_ext_clock_pin),
    .level   (pin_level[0]),
    .rise    (pin_rise[0]),
    .fall    (pin_fall[0])
  );

  tgts_pin_sync u_sync2 (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin     (second_ext_clock_pin),
    .level   (pin_level[1]),
    .rise    (pin_rise[1]),
    .fall    (pin_fall[1])
  );

  tgts_pin_sync u_sync3 (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin     (third_ext_clock_pin),
    .level   (pin_level[2]),
    .rise    (pin_rise[2]),
    .fall    (pin_fall[2])
  );

  // Extra alignment stage for the synchronised external path
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_edge1 <= 1'b0;
    end else begin
      sync_edge1 <= pin_rise[0];
    end
  end

  assign edge1 = first_timer_control[tgts_pkg::SYNC_BIT] ? sync_edge1 : pin_rise[0];

  // ****************************************
  // Effective configuration
  // ****************************************
  assign pair_wide_mode = second_timer_control[tgts_pkg::WIDE_BIT];
  assign cfg2 = second_timer_control;
  assign cfg3 = pair_wide_mode ? tgts_pkg::CTRL_RST : third_timer_control;

  // Run qualified by idle stop
  assign run[0] = first_timer_control[tgts_pkg::RUN_BIT]
                  && !(idle_mode && first_timer_control[tgts_pkg::IDLE_BIT]);
  assign run[1] = cfg2[tgts_pkg::RUN_BIT]
                  && !(idle_mode && cfg2[tgts_pkg::IDLE_BIT]);
  assign run[2] = cfg3[tgts_pkg::RUN_BIT] && !(idle_mode && cfg3[tgts_pkg::IDLE_BIT]);

  // Gate honoured only with internal clock
  assign gated[0] = first_timer_control[tgts_pkg::GATE_BIT]
                    && !first_timer_control[tgts_pkg::SRC_BIT];
  assign gated[1] = cfg2[tgts_pkg::GATE_BIT] && !cfg2[tgts_pkg::SRC_BIT];
  assign gated[2] = cfg3[tgts_pkg::GATE_BIT] && !cfg3[tgts_pkg::SRC_BIT];

  // ****************************************
  // Prescaler inputs
  // ****************************************
  always_comb begin
    ps_in[0] = first_timer_control[tgts_pkg::SRC_BIT] ? edge1
               : (!gated[0] || pin_level[0]);
    ps_in[1] = cfg2[tgts_pkg::SRC_BIT] ? pin_rise[1]
               : (!gated[1] || pin_level[1]);
    ps_in[2] = cfg3[tgts_pkg::SRC_BIT] ? pin_rise[2] : (!gated[2] || pin_level[2]);
    ps_in    = ps_in & run;
    ps_clear = ~run;
  end

  tgts_prescaler #(.CNT_W(8)) u_ps1 (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clear    (ps_clear[0]),
    .select   (first_timer_control[tgts_pkg::PS_MSB:tgts_pkg::PS_LSB]),
    .tick_in  (ps_in[0]),
    .tick_out (ps_tick[0])
  );

  tgts_prescaler #(.CNT_W(8)) u_ps2 (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clear    (ps_clear[1]),
    .select   (cfg2[tgts_pkg::PS_MSB:tgts_pkg::PS_LSB]),
    .tick_in  (ps_in[1]),
    .tick_out (ps_tick[1])
  );

  tgts_prescaler #(.CNT_W(8)) u_ps3 (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clear    (ps_clear[2]),
    .select   (cfg3[tgts_pkg::PS_MSB:tgts_pkg::PS_LSB]),
    .tick_in  (ps_in[2]),
    .tick_out (ps_tick[2])
  );

  // Gate falling edges while running gated
  assign gate_fall_ev = gated & run & pin_fall;

  // ****************************************
  // First timer counter
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      first_count <= tgts_pkg::COUNT_RST;
    end else if (wr_first_cnt) begin
      first_count <= reg_wdata;
    end else if (ps_tick[0]) begin
      first_count <= (first_count == first_period) ? tgts_pkg::COUNT_RST
                     : 16'(first_count + 16'h0001);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      first_irq <= 1'b0;
    end else begin
      first_irq <= (ps_tick[0] && (first_count == first_period)) || gate_fall_ev[0];
    end
  end

  // ****************************************
  // Pair counters
  // ****************************************
  assign wide_match = {pair_count_high, pair_count_low}
                      == {pair_period_high, pair_period_low};
  assign next_pair  = wide_match ? 32'h0000_0000
                      : 32'({pair_count_high, pair_count_low} + 32'h0000_0001);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pair_count_low <= tgts_pkg::COUNT_RST;
    end else if (wr_lo_cnt) begin
      pair_count_low <= reg_wdata;
    end else if (ps_tick[1] && pair_wide_mode) begin
      pair_count_low <= next_pair[15:0];
    end else if (ps_tick[1]) begin
      pair_count_low <= (pair_count_low == pair_period_low) ? tgts_pkg::COUNT_RST
                        : 16'(pair_count_low + 16'h0001);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pair_count_high <= tgts_pkg::COUNT_RST;
    end else if (wr_hi_cnt) begin
      pair_count_high <= reg_wdata;
    end else if (ps_tick[1] && pair_wide_mode) begin
      pair_count_high <= next_pair[31:16];
    end else if (ps_tick[2] && !pair_wide_mode) begin
      pair_count_high <= (pair_count_high == pair_period_high) ? tgts_pkg::COUNT_RST
                         : 16'(pair_count_high + 16'h0001);
    end
  end

  // ****************************************
  // Pair events and time bases
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      second_irq  <= 1'b0;
      third_irq   <= 1'b0;
      adc_trigger <= 1'b0;
    end else if (pair_wide_mode) begin
      second_irq  <= 1'b0;
      third_irq   <= (ps_tick[1] && wide_match) || gate_fall_ev[1];
      adc_trigger <= ps_tick[1] && wide_match;
    end else begin
      second_irq  <= (ps_tick[1] && (pair_count_low == pair_period_low)) || gate_fall_ev[1];
      third_irq   <= (ps_tick[2] && (pair_count_high == pair_period_high)) || gate_fall_ev[2];
      adc_trigger <= 1'b0;
    end
  end

  assign second_time_base = pair_count_low;
  assign third_time_base  = pair_count_high;

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr)
      tgts_pkg::OFS_FIRST_CTRL:  next_rdata = first_timer_control;
      tgts_pkg::OFS_FIRST_COUNT: next_rdata = first_count;
      tgts_pkg::OFS_FIRST_PER:   next_rdata = first_period;
      tgts_pkg::OFS_SECOND_CTRL: next_rdata = second_timer_control;
      tgts_pkg::OFS_PAIR_CNT_LO: next_rdata = pair_count_low;
      tgts_pkg::OFS_PAIR_PER_LO: next_rdata = pair_period_low;
      tgts_pkg::OFS_THIRD_CTRL:  next_rdata = third_timer_control;
      tgts_pkg::OFS_PAIR_CNT_HI: next_rdata = pair_count_high;
      tgts_pkg::OFS_PAIR_PER_HI: next_rdata = pair_period_high;
      default:                   next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_re ? next_rdata : 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_ctrl_rsvd_zero: assert property (
    reg_re && reg_addr == tgts_pkg::OFS_FIRST_CTRL |=> (reg_rdata & 16'h5F89) == 16'h0000)
    else $error("reserved first control bits read nonzero");

  a_ctrl_write_back: assert property (
    reg_we && reg_addr == tgts_pkg::OFS_FIRST_CTRL ##1 !reg_we ##1 reg_re
      && reg_addr == tgts_pkg::OFS_FIRST_CTRL
      |=> reg_rdata == ($past(reg_wdata, 3) & 16'hA076))
    else $error("first control readback mismatch");

  a_stop_holds_count: assert property (
    !first_timer_control[15] && !wr_first_cnt |=> $stable(first_count))
    else $error("first count moved while stopped");

  a_idle_stop_halt: assert property (
    idle_mode && first_timer_control[13] && !wr_first_cnt |=> $stable(first_count))
    else $error("first count moved in idle with stop set");

  a_period_wrap: assert property (
    ps_tick[0] && first_count == first_period && !wr_first_cnt
      |=> first_count == 16'h0000 && first_irq)
    else $error("first timer missed period wrap");

  a_wide_irq_third: assert property (
    pair_wide_mode && ps_tick[1] && wide_match |=> third_irq && !second_irq && adc_trigger)
    else $error("wide match not signalled on third flag");

  a_adc_only_wide: assert property (
    adc_trigger |-> $past(pair_wide_mode))
    else $error("adc trigger outside wide mode");

  a_gate_low_hold: assert property (
    gated[0] && !pin_level[0] && !wr_first_cnt |=> $stable(first_count))
    else $error("first timer counted with gate low");

  a_wide_carry: assert property (
    pair_wide_mode && ps_tick[1] && !wide_match && pair_count_low == 16'hFFFF
      && !wr_lo_cnt && !wr_hi_cnt |=> pair_count_low == 16'h0000
      && pair_count_high == 16'($past(pair_count_high) + 16'h0001))
    else $error("wide carry into high word lost");

  c_first_irq: cover property (first_irq);
  c_wide_wrap: cover property (pair_wide_mode && adc_trigger);
  c_gate_fall: cover property (gate_fall_ev[0] ##1 first_irq);
  c_split_irqs: cover property (!pair_wide_mode && second_irq ##[1:50] third_irq);

endmodule

// ===== tgts_pin_model.sv
// Purpose: Model of the external clock and gate pins of the timer set
// Assumes: Pins idle low through a pull-down
// Notes:   Edges are launched just after a clk_sys edge
`timescale 1ns/10ps
module tgts_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Pins
  output logic      [2:0] pins
);
  initial pins = 3'b000;

  // Rising edges six clocks apart, each held high three clocks
  task automatic pulse(input int ch, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      pins[ch] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pins[ch] <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  // Gate level held until changed
  task automatic set_level(input int ch, input logic v);
    @(posedge clk_sys);
    pins[ch] <= v;
  endtask
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench of the timer set
// Assumes: Word offsets and masks of tgts_pkg
// Notes:   Intervals between event pulses are measured in clocks
`timescale 1ns/10ps
module tb_top;
  // Design signals
  logic        clk_sys;
  logic        sys_rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [15:0] reg_rdata;
  logic        idle_mode;
  logic [2:0]  pins;
  logic [3:0]  irqs;
  logic [15:0] tb2;
  logic [15:0] tb3;
  // Bench state
  logic [15:0] d;
  int          n_fail;
  int          comparisons;
  int          n;
  int          k;
  int          div [4] = '{1, 8, 64, 256};

  tgts_timer_set dut_u (
    .clk_sys                   (clk_sys),
    .sys_rst                   (sys_rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_we                    (reg_we),
    .reg_re                    (reg_re),
    .reg_rdata                 (reg_rdata),
    .idle_mode                 (idle_mode),
    .first_timer_ext_clock_pin (pins[0]),
    .second_ext_clock_pin      (pins[1]),
    .third_ext_clock_pin       (pins[2]),
    .first_irq                 (irqs[0]),
    .second_irq                (irqs[1]),
    .third_irq                 (irqs[2]),
    .adc_trigger               (irqs[3]),
    .second_time_base          (tb2),
    .third_time_base           (tb3)
  );

  tgts_pin_model pin_u (
    .clk_sys (clk_sys),
    .pins    (pins)
  );

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Clocks between two pulses of irqs[idx], 0 if none
  task automatic gap(input int idx, input int lim, input bit must, output int g);
    int i;
    g = 0;
    for (i = 0; i < lim && irqs[idx] !== 1'b1; i++) @(posedge clk_sys) #1;
    if (irqs[idx] === 1'b1) begin
      for (g = 1; g < lim; g++) begin
        @(posedge clk_sys) #1;
        if (irqs[idx] === 1'b1) break;
      end
    end
    if (must && (g == 0 || g == lim)) begin
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    idle_mode = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Register reset values and masks
    rd(tgts_pkg::OFS_FIRST_CTRL, d);
    chk(d, 16'h0000);
    rd(tgts_pkg::OFS_FIRST_PER, d);
    chk(d, tgts_pkg::PERIOD_RST);
    wr(tgts_pkg::OFS_FIRST_CTRL, 16'hFFFF);
    rd(tgts_pkg::OFS_FIRST_CTRL, d);
    chk(d, 16'hA076);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'hFFFF);
    rd(tgts_pkg::OFS_SECOND_CTRL, d);
    chk(d, 16'hA07A);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h0000);
    rd(4'hF, d);
    chk(d, 16'h0000);
    $display("test registers done");
    // Prescale codes with period 1
    wr(tgts_pkg::OFS_FIRST_PER, 16'h0001);
    for (k = 0; k < 4; k++) begin
      wr(tgts_pkg::OFS_FIRST_CTRL, 16'h0000);
      wr(tgts_pkg::OFS_FIRST_CTRL, 16'h8000 | 16'(k << 4));
      gap(0, 600, 1'b1, n);
      chk(16'(n), 16'(2 * div[k]));
    end
    $display("test prescale done");
    // Idle stop
    idle_mode <= 1'b1;
    wr(tgts_pkg::OFS_FIRST_CTRL, 16'hA000);
    gap(0, 60, 1'b0, n);
    chk(16'(n), 16'h0000);
    wr(tgts_pkg::OFS_FIRST_CTRL, 16'h8000);
    gap(0, 60, 1'b1, n);
    chk(16'(n), 16'h0002);
    idle_mode <= 1'b0;
    $display("test idle done");
    // Gated accumulation
    wr(tgts_pkg::OFS_FIRST_CTRL, 16'h8040);
    gap(0, 60, 1'b0, n);
    chk(16'(n), 16'h0000);
    pin_u.set_level(0, 1'b1);
    gap(0, 60, 1'b1, n);
    chk(16'(n), 16'h0002);
    pin_u.set_level(0, 1'b0);
    $display("test gate done");
    // External clock, plain and synchronised
    for (k = 0; k < 2; k++) begin
      wr(tgts_pkg::OFS_FIRST_CTRL, 16'h0000);
      wr(tgts_pkg::OFS_FIRST_COUNT, 16'h0000);
      wr(tgts_pkg::OFS_FIRST_PER, 16'hFFFF);
      wr(tgts_pkg::OFS_FIRST_CTRL, 16'h8002 | 16'(k << 2));
      pin_u.pulse(0, 5);
      repeat (10) @(posedge clk_sys);
      rd(tgts_pkg::OFS_FIRST_COUNT, d);
      chk(d, 16'h0005);
    end
    $display("test external clock done");
    // Second and third timers as separate 16-bit timers
    wr(tgts_pkg::OFS_PAIR_PER_HI, 16'h0001);
    wr(tgts_pkg::OFS_PAIR_PER_LO, 16'h0001);
    wr(tgts_pkg::OFS_THIRD_CTRL, 16'h8000);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h8000);
    gap(2, 60, 1'b1, n);
    chk(16'(n), 16'h0002);
    gap(1, 60, 1'b1, n);
    chk(16'(n), 16'h0002);
    wr(tgts_pkg::OFS_THIRD_CTRL, 16'h0000);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h0000);
    // Wide mode, run bit last
    wr(tgts_pkg::OFS_PAIR_PER_LO, 16'h0003);
    wr(tgts_pkg::OFS_PAIR_PER_HI, 16'h0000);
    wr(tgts_pkg::OFS_PAIR_CNT_LO, 16'h0000);
    wr(tgts_pkg::OFS_PAIR_CNT_HI, 16'h0000);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h8008);
    gap(2, 60, 1'b1, n);
    chk(16'(n), 16'h0004);
    gap(3, 60, 1'b1, n);
    chk(16'(n), 16'h0004);
    gap(1, 30, 1'b0, n);
    chk(16'(n), 16'h0000);
    // Wide timer through Idle, then halted by idle stop
    idle_mode <= 1'b1;
    gap(2, 60, 1'b1, n);
    chk(16'(n), 16'h0004);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'hA008);
    gap(2, 30, 1'b0, n);
    chk(16'(n), 16'h0000);
    idle_mode <= 1'b0;
    // Carry from low into high word
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h0000);
    wr(tgts_pkg::OFS_PAIR_PER_LO, 16'hFFFF);
    wr(tgts_pkg::OFS_PAIR_PER_HI, 16'hFFFF);
    wr(tgts_pkg::OFS_PAIR_CNT_LO, 16'hFFFE);
    wr(tgts_pkg::OFS_THIRD_CTRL, 16'h8030);
    wr(tgts_pkg::OFS_SECOND_CTRL, 16'h8008);
    repeat (8) @(posedge clk_sys);
    rd(tgts_pkg::OFS_PAIR_CNT_HI, d);
    chk(d, 16'h0001);
    chk(tb3, 16'h0001);
    $display("test wide mode done");
    end_sim();
  end
endmodule
